// [pisc_pkg.sv]
// Shared constants and types for the power sequencing control block
// What this block does
// RULE_01 - Sequenced variant: each supply starts only once the previous one is valid.
// RULE_02 - Newly enabled upstream supply drops downstream ones; they restart in chain order.
// RULE_03 - Variant without sequencing starts every enabled supply on its own.
// RULE_04 - Host may write all four enables together with inhibit clear.
// RULE_05 - Host may let sequencing run when starting from all supplies off.
// RULE_06 - With any supply on, host sets inhibit before switching supplies.
// RULE_07 - After partial register enable, host must not use the trigger pin edge.
// RULE_08 - Last supply in the chain may be switched at any time.
// RULE_09 - Default order fixed per variant: 0, 2 sequenced; 9 buck only.
// RULE_10 - Target answers at seven-bit address 1011010, write byte b4.
// RULE_11 - Write: address with write bit, pointer byte, data byte, all acknowledged.
// RULE_12 - Read: pointer write, repeated start, address with read bit, data out.
// RULE_13 - Only the low three pointer bits select a register.
// RULE_14 - Six registers: enable, status, buck and three linear voltage codes.
// RULE_15 - Enable bits switch supplies; inhibit bit bypasses chain-order start.
// RULE_16 - Rising trigger pin edge reloads defaults and runs default start-up.
// RULE_17 - Inhibit bit exists only in sequenced variants, else reads zero.
// RULE_18 - Status: read-only valid bits, sticky fault flags, interrupt enable bit.
// RULE_19 - Fault flag stays set until a one is written to it.
// RULE_20 - A still-present fault sets its flag again at once.
// RULE_21 - Buck code has fine steps to 1.2 V and coarse steps above.
// RULE_22 - Buck code 00 is 0.8 V plus 25 mV steps; 10..1c 50 mV steps.
// RULE_23 - Fault turns outputs off, sets flag, reloads enables and voltages.
// RULE_24 - With interrupt enabled, interrupt pin low while any fault flag set.
// RULE_25 - Pointers 06 and 07 read zero; writes acknowledged and ignored.
// RULE_26 - Reset loads defaults: restart-after-fault one, others cleared.
package pisc_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [2:0] REG_ENABLE = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_BUCK   = 3'h2;
    localparam logic [2:0] REG_LREG_A = 3'h3;
    localparam logic [2:0] REG_LREG_B = 3'h4;
    localparam logic [2:0] REG_LREG_C = 3'h5;
    localparam int EN_RESTART_BIT = 5;
    localparam int EN_INHIBIT_BIT = 4;
    localparam int ST_IRQ_EN_BIT  = 6;
    localparam int ST_UV_BIT      = 5;
    localparam int ST_OT_BIT      = 4;
    localparam logic [6:0] TARGET_ADDR = 7'h5a;
    // Supply index order inside 4-bit vectors: 0 buck, 1 lreg a, 2 lreg b, 3 lreg c
    localparam logic [3:0] SUPPLY_ALL  = 4'hf;
    localparam logic [3:0] SUPPLY_BUCK = 4'h1;
    // Voltage code defaults; arbitrary plain values
    localparam logic [7:0] BUCK_CODE_RST = 8'h10;
    localparam logic [7:0] LREG_CODE_RST = 8'h85;
    // Start-up variant numbers
    localparam logic [3:0] VARIANT_0 = 4'h0;
    localparam logic [3:0] VARIANT_2 = 4'h2;
    localparam logic [3:0] VARIANT_9 = 4'h9;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       restart_after_fault;
        logic       sequencing_inhibit;
        logic [3:0] supply_on;
    } pisc_enable_type;

    typedef struct packed {
        logic wr;
        logic [2:0] ptr;
        logic [7:0] data;
    } pisc_write_type;

endpackage

// [pisc_i2c_target.sv]
// I2C target that turns bus frames into register pointer writes and reads
`timescale 1ns/1ns
`default_nettype none
module pisc_i2c_target
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output logic                           sda_oe,
    output pisc_pkg::pisc_write_type       wr_req,
    output logic [2:0]                     rd_ptr,
    input  wire logic [7:0]                rd_data
);
    typedef enum { ST_IDLE, ST_ADDR, ST_ACK, ST_PTR, ST_DATA, ST_TX, ST_MACK } pisc_i2c_state_type;

    // ------------------------------------------------------------
    // Pin synchronisers: three stages, change seen when 2nd and 3rd agree
    // ------------------------------------------------------------
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    always_ff @(posedge clk_sys)
    begin
        scl_sync <= {scl_sync[1:0], scl_in};
        sda_sync <= {sda_sync[1:0], sda_in};
    end
    // Filtered levels only move when the two later stages agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            if (scl_sync[1] == scl_sync[2])
                scl_q <= scl_sync[2];
            if (sda_sync[1] == sda_sync[2])
                sda_q <= sda_sync[2];
        end
    end
    logic scl_d;
    logic sda_d;
    always_ff @(posedge clk_sys)
    begin
        scl_d <= scl_q;
        sda_d <= sda_q;
    end
    wire scl_rise = scl_q & ~scl_d;
    wire scl_fall = ~scl_q & scl_d;
    wire start_cond = scl_q & scl_d & sda_d & ~sda_q;
    wire stop_cond  = scl_q & scl_d & ~sda_d & sda_q;

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    pisc_i2c_state_type state;
    pisc_i2c_state_type ack_next;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic       got_ptr;
    logic [2:0] ptr;
    logic       drive_low;
    wire        byte_done = (bit_cnt == 4'h8);
    wire        addr_hit  = (shift[7:1] == pisc_pkg::TARGET_ADDR); // RULE_10

    assign sda_oe = drive_low;
    assign rd_ptr = ptr;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state     <= ST_IDLE;
            ack_next  <= ST_IDLE;
            shift     <= 8'h00;
            bit_cnt   <= 4'h0;
            got_ptr   <= 1'b0;
            ptr       <= 3'h0;
            drive_low <= 1'b0;
            wr_req    <= '0;
        end
        else
        begin
            wr_req.wr <= 1'b0;
            if (start_cond)
            begin
                // Repeated start keeps the pointer for the read phase
                state     <= ST_ADDR; // RULE_12
                bit_cnt   <= 4'h0;
                got_ptr   <= 1'b0;
                drive_low <= 1'b0;
            end
            else if (stop_cond)
            begin
                state     <= ST_IDLE;
                drive_low <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_ADDR, ST_PTR, ST_DATA:
                    begin
                        if (scl_rise)
                        begin
                            shift   <= {shift[6:0], sda_q};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && byte_done)
                        begin
                            bit_cnt <= 4'h0;
                            if (state == ST_ADDR && !addr_hit)
                                state <= ST_IDLE;
                            else
                            begin
                                drive_low <= 1'b1; // RULE_11
                                state     <= ST_ACK;
                                if (state == ST_ADDR)
                                    ack_next <= shift[0] ? ST_TX : ST_PTR;
                                else if (state == ST_PTR)
                                begin
                                    ptr      <= shift[2:0]; // RULE_13
                                    got_ptr  <= 1'b1;
                                    ack_next <= ST_DATA;
                                end
                                else
                                begin
                                    wr_req.wr   <= got_ptr; // RULE_11
                                    wr_req.ptr  <= ptr;
                                    wr_req.data <= shift;
                                    ack_next    <= ST_DATA;
                                end
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state <= ack_next;
                            if (ack_next == ST_TX)
                            begin
                                shift     <= rd_data; // RULE_12
                                drive_low <= ~rd_data[7];
                            end
                            else
                                drive_low <= 1'b0;
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7)
                            begin
                                drive_low <= 1'b0;
                                state     <= ST_MACK;
                            end
                            else
                            begin
                                shift     <= {shift[6:0], 1'b0};
                                drive_low <= ~shift[6];
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        // Ninth slot ends a single-byte read whatever the host answers; stop follows
                        if (scl_fall)
                            state <= ST_IDLE;
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [pisc_top.sv]
// Register bank, start-up sequencer and fault handling of the power controller
`timescale 1ns/1ns
`default_nettype none
module pisc_top
#(
    parameter logic [3:0] VARIANT = pisc_pkg::VARIANT_0
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       start_pin,
    input  wire logic [3:0] supply_valid,
    input  wire logic       input_undervoltage,
    input  wire logic       overtemp,
    output logic [3:0]      supply_start,
    output logic [7:0]      buck_code,
    output logic [7:0]      linear_reg_a_code,
    output logic [7:0]      linear_reg_b_code,
    output logic [7:0]      linear_reg_c_code,
    output logic            fault_irq_n
);
    // ------------------------------------------------------------
    // Variant decode
    // ------------------------------------------------------------
    localparam logic SEQ_VARIANT = (VARIANT != pisc_pkg::VARIANT_9); // RULE_17
    // Chain position of each supply (buck, a, b, c) per variant; RULE_09
    localparam logic [1:0] POS_BUCK = (VARIANT == pisc_pkg::VARIANT_0) ? 2'd1 : 2'd0;
    localparam logic [1:0] POS_A    = (VARIANT == pisc_pkg::VARIANT_0) ? 2'd0 : 2'd1;
    localparam logic [3:0] DEF_ON   = SEQ_VARIANT ? pisc_pkg::SUPPLY_ALL
                                                  : pisc_pkg::SUPPLY_BUCK; // RULE_09

    // ------------------------------------------------------------
    // Bus target
    // ------------------------------------------------------------
    pisc_pkg::pisc_write_type wr_req;
    logic [2:0] rd_ptr;
    logic [7:0] rd_data;
    assign sda_out = 1'b0; // Open drain: only ever pulls low

    pisc_i2c_target u_target
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_oe  (sda_oe),
        .wr_req  (wr_req),
        .rd_ptr  (rd_ptr),
        .rd_data (rd_data)
    );

    // ------------------------------------------------------------
    // Pin and fault input synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_sync;
    logic [2:0] uv_sync;
    logic [2:0] ot_sync;
    logic       pin_q;
    logic       pin_d;
    logic       uv_q;
    logic       ot_q;
    always_ff @(posedge clk_sys)
    begin
        pin_sync <= {pin_sync[1:0], start_pin};
        uv_sync  <= {uv_sync[1:0], input_undervoltage};
        ot_sync  <= {ot_sync[1:0], overtemp};
    end
    // Accept a change once the two later stages agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_q <= 1'b0;
            pin_d <= 1'b0;
            uv_q  <= 1'b0;
            ot_q  <= 1'b0;
        end
        else
        begin
            if (pin_sync[1] == pin_sync[2])
                pin_q <= pin_sync[2];
            if (uv_sync[1] == uv_sync[2])
                uv_q <= uv_sync[2];
            if (ot_sync[1] == ot_sync[2])
                ot_q <= ot_sync[2];
            pin_d <= pin_q;
        end
    end
    wire pin_rise = pin_q & ~pin_d;
    wire pin_fall = ~pin_q & pin_d;
    wire fault    = uv_q | ot_q;
    logic fault_d;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            fault_d <= 1'b0;
        else
            fault_d <= fault;
    end
    wire fault_gone = fault_d & ~fault;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    pisc_pkg::pisc_enable_type ctl;
    logic       irq_en;
    logic       uv_flag;
    logic       ot_flag;
    logic [7:0] vcode [4];

    wire wr_en  = wr_req.wr && wr_req.ptr == pisc_pkg::REG_ENABLE;
    wire wr_st  = wr_req.wr && wr_req.ptr == pisc_pkg::REG_STATUS;
    wire [2:0] wr_off = wr_req.ptr - pisc_pkg::REG_BUCK;
    // A restart after fault clears, or the trigger pin edge, loads defaults
    wire do_default = pin_rise || (fault_gone && ctl.restart_after_fault); // RULE_16

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctl    <= '{restart_after_fault: 1'b1, sequencing_inhibit: 1'b0,
                        supply_on: 4'h0}; // RULE_26
            irq_en <= 1'b0;
            vcode  <= '{pisc_pkg::BUCK_CODE_RST, pisc_pkg::LREG_CODE_RST,
                        pisc_pkg::LREG_CODE_RST, pisc_pkg::LREG_CODE_RST};
        end
        else if (fault)
        begin
            // Outputs off and defaults back; restart bit is kept
            ctl.sequencing_inhibit <= 1'b0; // RULE_23
            ctl.supply_on          <= 4'h0;
            vcode <= '{pisc_pkg::BUCK_CODE_RST, pisc_pkg::LREG_CODE_RST,
                       pisc_pkg::LREG_CODE_RST, pisc_pkg::LREG_CODE_RST};
        end
        else if (do_default)
        begin
            ctl.sequencing_inhibit <= 1'b0; // RULE_16
            ctl.supply_on          <= DEF_ON;
            vcode <= '{pisc_pkg::BUCK_CODE_RST, pisc_pkg::LREG_CODE_RST,
                       pisc_pkg::LREG_CODE_RST, pisc_pkg::LREG_CODE_RST};
        end
        else if (pin_fall)
            ctl.supply_on <= 4'h0;
        else if (wr_req.wr)
        begin
            // Pointers 6 and 7 fall through every case and are dropped
            if (wr_en)
            begin
                ctl.restart_after_fault <= wr_req.data[pisc_pkg::EN_RESTART_BIT];
                ctl.sequencing_inhibit  <= SEQ_VARIANT
                                           & wr_req.data[pisc_pkg::EN_INHIBIT_BIT]; // RULE_17
                ctl.supply_on           <= wr_req.data[3:0]; // RULE_15
            end
            if (wr_st)
                irq_en <= wr_req.data[pisc_pkg::ST_IRQ_EN_BIT];
            if (wr_req.ptr >= pisc_pkg::REG_BUCK && wr_req.ptr <= pisc_pkg::REG_LREG_C)
                vcode[wr_off[1:0]] <= wr_req.data; // RULE_14
        end
    end

    // Sticky fault flags: a live fault wins over the one-write clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            uv_flag <= 1'b0;
            ot_flag <= 1'b0;
        end
        else
        begin
            uv_flag <= uv_q | (uv_flag & ~(wr_st & wr_req.data[pisc_pkg::ST_UV_BIT])); // RULE_19 RULE_20
            ot_flag <= ot_q | (ot_flag & ~(wr_st & wr_req.data[pisc_pkg::ST_OT_BIT])); // RULE_19 RULE_20
        end
    end

    // ------------------------------------------------------------
    // Start chain: each supply gated by its predecessor's valid level
    // ------------------------------------------------------------
    logic [3:0] pos [4];
    assign pos[0] = {2'b00, POS_BUCK};
    assign pos[1] = {2'b00, POS_A};
    assign pos[2] = 4'h2;
    assign pos[3] = 4'h3; // Last place gates no one: RULE_08
    logic [3:0] chain_gate;
    logic [3:0] next_start;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_chain
            // Predecessor is the supply one position earlier in the order
            logic pred_ok;
            always_comb
            begin
                pred_ok = 1'b1;
                for (int k = 0; k < 4; k++)
                    if (pos[k] + 4'h1 == pos[g] && ctl.supply_on[k])
                        pred_ok = supply_valid[k] & chain_gate[k]; // RULE_01 RULE_02
            end
            assign chain_gate[g] = (pos[g] == 4'h0) ? 1'b1 : pred_ok;
            // Disabled supplies drop out of the chain and are skipped
            assign next_start[g] = ctl.supply_on[g] &
                (~SEQ_VARIANT | ctl.sequencing_inhibit | chain_gate[g]); // RULE_03 RULE_15
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            supply_start <= 4'h0;
        else
            supply_start <= fault ? 4'h0 : next_start; // RULE_23
    end

    // ------------------------------------------------------------
    // Read mux and output pins
    // ------------------------------------------------------------
    wire [7:0] status_rd = {1'b0, irq_en, uv_flag, ot_flag, supply_valid}; // RULE_18
    wire [2:0] rd_off = rd_ptr - pisc_pkg::REG_BUCK;
    assign rd_data = (rd_ptr == pisc_pkg::REG_ENABLE) ? {2'b00, ctl} :
                     (rd_ptr == pisc_pkg::REG_STATUS) ? status_rd :
                     (rd_ptr <= pisc_pkg::REG_LREG_C) ? vcode[rd_off[1:0]] :
                     8'h00; // RULE_25

    // Buck code is passed as stored; the step table lives in the analog part
    assign buck_code         = vcode[0]; // RULE_21 RULE_22
    assign linear_reg_a_code = vcode[1];
    assign linear_reg_b_code = vcode[2];
    assign linear_reg_c_code = vcode[3];

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            fault_irq_n <= 1'b1;
        else
            fault_irq_n <= ~(irq_en & (uv_flag | ot_flag)); // RULE_24
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fault_kills_out: assert property (@(posedge clk_sys) disable iff (rst)
        fault |=> supply_start == 4'h0) else $error("Supply on during fault"); // RULE_23
    a_flag_sticks: assert property (@(posedge clk_sys) disable iff (rst)
        uv_flag && !wr_st |=> uv_flag) else $error("Flag lost without clear"); // RULE_19
    a_flag_reset_live: assert property (@(posedge clk_sys) disable iff (rst)
        ot_q |=> ot_flag) else $error("Live fault flag not set"); // RULE_20
    a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
        irq_en && uv_flag |=> !fault_irq_n) else $error("Interrupt not raised"); // RULE_24
    a_irq_masked: assert property (@(posedge clk_sys) disable iff (rst)
        !irq_en |=> fault_irq_n) else $error("Interrupt raised while masked"); // RULE_24
    a_no_chain_plain: assert property (@(posedge clk_sys) disable iff (rst)
        !SEQ_VARIANT && !fault |=> supply_start == $past(ctl.supply_on))
        else $error("Chained start in plain variant"); // RULE_03
    a_inhibit_zero: assert property (@(posedge clk_sys) disable iff (rst)
        !SEQ_VARIANT |-> !ctl.sequencing_inhibit) else $error("Inhibit set in plain variant"); // RULE_17
    a_pin_default: assert property (@(posedge clk_sys) disable iff (rst)
        pin_rise && !fault |=> ctl.supply_on == DEF_ON) else $error("Default not loaded"); // RULE_16
endmodule
`default_nettype wire

// [pisc_host.sv]
// I2C host model that drives the register bus of the power controller
`timescale 1ns/1ns
`default_nettype none
module pisc_host
(
    input  wire logic clk_sys,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic drv = 1'b1;

    // Pull-up on the bus: low whenever either side pulls it
    assign sda = drv & ~sda_oe;
    initial scl = 1'b1;

    // -----------------------------------------------------------
    // Bus timing
    // -----------------------------------------------------------
    // Each SCL phase is 12 clocks, so the target's synchroniser always keeps up
    task automatic half();
        repeat (12) @(negedge clk_sys);
    endtask

    // Data set while SCL is low, sampled just before SCL falls
    task automatic slot(input logic b, output logic s);
        drv = b;
        half();
        scl = 1'b1;
        half();
        s = sda;
        scl = 1'b0;
    endtask

    // Start and repeated start share one shape
    task automatic start();
        drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        drv = 1'b0;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        drv = 1'b1;
        half();
    endtask

    // MSB first; ninth slot released so the target can acknowledge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            slot(tx[i], s);
            rx[i] = s;
        end
        slot(1'b1, s);
        ack = ~s;
    endtask

    // -----------------------------------------------------------
    // Register transfers
    // -----------------------------------------------------------
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] x;
        logic       a0, a1, a2;
        start();
        xfer(8'hb4, x, a0);
        xfer(p, x, a1);
        xfer(d, x, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // Read byte ends with a released ninth slot, a no-acknowledge
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic [7:0] x;
        logic       a0, a1, a2, a3;
        start();
        xfer(8'hb4, x, a0);
        xfer(p, x, a1);
        start();
        xfer(8'hb5, x, a2);
        xfer(8'hff, d, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the power controller registers and sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       scl, sda, sda_oe, irq_n, ok;
    logic       start_pin = 1'b0;
    logic [3:0] supply_valid = 4'h0;
    logic [3:0] vmask = 4'hf;
    logic [1:0] fault = 2'h0;
    logic [3:0] supply_start, start9;
    logic [7:0] code [4];
    logic [7:0] rdat;
    int         error_cnt = 0;
    int         check_count = 0;

    always #5 clk_sys = ~clk_sys;
    // Power-good follows the start half a cycle later, at the falling edge, unless held off by vmask
    always @(negedge clk_sys) supply_valid <= supply_start & vmask;

    pisc_top #(.VARIANT(pisc_pkg::VARIANT_2)) DUT
    (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .start_pin(start_pin), .supply_valid(supply_valid),
        .input_undervoltage(fault[1]), .overtemp(fault[0]),
        .supply_start(supply_start), .buck_code(code[0]), .linear_reg_a_code(code[1]),
        .linear_reg_b_code(code[2]), .linear_reg_c_code(code[3]), .fault_irq_n(irq_n)
    );

    pisc_host HOST (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    pisc_top #(.VARIANT(pisc_pkg::VARIANT_9)) DUT9
    (
        .clk_sys(clk_sys), .rst(rst), .scl_in(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
        .start_pin(start_pin), .supply_valid(4'h0), .input_undervoltage(1'b0),
        .overtemp(1'b0), .supply_start(start9), .buck_code(), .linear_reg_a_code(),
        .linear_reg_b_code(), .linear_reg_c_code(), .fault_irq_n()
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        HOST.wr(p, d, ok);
        chk({7'h0, ok}, 8'h01);
    endtask

    task automatic rd(input logic [7:0] p, input logic [7:0] exp, input logic [7:0] m);
        HOST.rd(p, rdat, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rdat & m, exp);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    initial
    begin
        wait_clk(4);
        rst = 1'b0;
        wait_clk(8);
        rd(8'h00, 8'h20, 8'hff);
        rd(8'h01, 8'h00, 8'hff);
        chk(code[0], pisc_pkg::BUCK_CODE_RST);
        // Pin edge only from all off, never after a partial enable
        start_pin = 1'b1;
        wait_clk(40);
        chk({4'h0, supply_start}, 8'h0f);
        chk({4'h0, start9}, 8'h01);
        rd(8'h00, 8'h2f, 8'hff);
        rd(8'h01, 8'h0f, 8'h8f);
        // Pointer upper bits are ignored
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hfa + 8'(i), 8'h0b + 8'(i));
            chk(code[i], 8'h0b + 8'(i));
            rd(8'h02 + 8'(i), 8'h0b + 8'(i), 8'hff);
        end
        wr(8'h06, 8'h55);
        rd(8'h06, 8'h00, 8'hff);
        wr(8'h01, 8'h4f);
        // Overtemperature first, then undervoltage
        for (int f = 0; f < 2; f++)
        begin
            fault[f] = 1'b1;
            wait_clk(20);
            chk({4'h0, supply_start}, 8'h00);
            chk(code[0], pisc_pkg::BUCK_CODE_RST);
            chk({7'h0, irq_n}, 8'h00);
            wr(8'h01, 8'h70);
            rd(8'h01, 8'h10 << f, 8'h30);
            fault[f] = 1'b0;
            wait_clk(20);
            rd(8'h01, 8'h40 | (8'h10 << f), 8'h70);
            chk({4'h0, supply_start}, 8'h0f);
            wr(8'h01, 8'h40 | (8'h10 << f));
            rd(8'h01, 8'h40, 8'h70);
            chk({7'h0, irq_n}, 8'h01);
        end
        // Inhibit before switching off, then chained start from all off
        wr(8'h00, 8'h30);
        vmask = 4'h0;
        wr(8'h00, 8'h23);
        chk({4'h0, supply_start}, 8'h01);
        wr(8'h00, 8'h30);
        wr(8'h00, 8'h2f);
        for (int s = 0; s < 4; s++)
        begin
            wait_clk(20);
            chk({4'h0, supply_start}, 8'((2 << s) - 1));
            vmask[s] = 1'b1;
        end
        wr(8'h00, 8'h3d);
        vmask = 4'hd;
        wait_clk(20);
        chk({4'h0, supply_start}, 8'h0d);
        // Upstream re-enabled with chaining: downstream drops, then restarts
        wr(8'h00, 8'h2f);
        chk({4'h0, supply_start}, 8'h03);
        vmask = 4'hf;
        wait_clk(20);
        chk({4'h0, supply_start}, 8'h0f);
        wr(8'h00, 8'h27);
        chk({4'h0, supply_start}, 8'h07);
        end_sim();
    end

    // About 32 transfers of some 720 to 970 cycles each; the limit leaves ample slack
    initial
    begin
        #900000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
